/* wlbs_pkg.sv */
package wlbs_pkg;

  // register offsets (12-bit apb address)
  localparam logic [11:0] WLBS_OFS_LOCK = 12'h000;
  localparam logic [11:0] WLBS_OFS_BANK = 12'h004;
  localparam logic [11:0] WLBS_OFS_CFG = 12'h080;
  // bank window bounds for the programming registers
  localparam logic [11:0] WLBS_BANK_A_LO = 12'h100;
  localparam logic [11:0] WLBS_BANK_A_HI = 12'h344;
  localparam logic [11:0] WLBS_BANK_B_LO = 12'h500;
  localparam logic [11:0] WLBS_BANK_B_HI = 12'h744;

  // lock keys and field positions
  localparam logic [15:0] WLBS_KEY_LOCK = 16'hC705;
  localparam logic [15:0] WLBS_KEY_UNLOCK = 16'h5E5A;
  localparam int WLBS_KEY_MSB = 31;
  localparam int WLBS_KEY_LSB = 16;
  localparam int WLBS_LOCK_BIT = 0;
  localparam int WLBS_BANK_BIT = 0;
  localparam logic WLBS_LOCK_RST = 1'b0;
  localparam logic WLBS_BANK_INIT = 1'b0;

  // build parameter codes
  localparam logic [1:0] WLBS_IF_ZERO = 2'h0;
  localparam logic [1:0] WLBS_IF_QUARTER = 2'h1;
  localparam logic [3:0] WLBS_STD_LTE = 4'h0;
  localparam logic [3:0] WLBS_STD_TDSCDMA = 4'h1;
  localparam logic [5:0] WLBS_BW_LTE_1M4 = 6'h01;
  localparam logic [5:0] WLBS_BW_LTE_3M = 6'h03;
  localparam logic [5:0] WLBS_BW_LTE_5M = 6'h05;
  localparam logic [5:0] WLBS_BW_LTE_10M = 6'h0A;
  localparam logic [5:0] WLBS_BW_LTE_15M = 6'h0F;
  localparam logic [5:0] WLBS_BW_LTE_20M = 6'h14;
  localparam logic [5:0] WLBS_BW_TD_1M6 = 6'h02;
  localparam logic [5:0] WLBS_CARRIER_MASK = 6'h3F;

  // wait states before pready
  localparam logic [2:0] WLBS_WAIT_STATES = 3'h3;
  // depth of the output valid hold-off after a datapath reset
  localparam logic [7:0] WLBS_PIPE_DEPTH = 8'h10;

  // configuration register layout
  typedef struct packed {
    logic [3:0] sbz;
    logic [1:0] if_code;
    logic [5:0] channel_width_code;
    logic [3:0] std_code;
    logic core_ddc;
    logic gain_prog;
    logic phase_prog;
    logic freq_prog;
    logic [5:0] antennas;
    logic [5:0] carriers;
  } wlbs_cfg_t;

  // apb request as seen by the decoder
  typedef struct packed {
    logic write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } wlbs_req_t;

  // decode result for one access
  typedef struct packed {
    logic hit_lock;
    logic hit_bank;
    logic hit_cfg;
    logic hit_active;
  } wlbs_dec_t;

  function automatic logic wlbs_in_range(input logic [11:0] a, input logic [11:0] lo, input logic [11:0] hi);
    wlbs_in_range = (a >= lo) && (a <= hi);
  endfunction

endpackage

/* wlbs_valid_gate.sv */
`timescale 1ns/1ps
// holds output valid low after a datapath reset until the pipeline refills
module wlbs_valid_gate
  import wlbs_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic srst_in,
  // datapath side
  input wire logic dp_reset_in,
  input wire logic sample_in_valid_in,
  input wire logic raw_valid_in,
  output logic output_sample_valid_out
);

  logic [7:0] fill_r;
  logic [7:0] fill_nxt;
  logic valid_r;
  logic valid_nxt;

  // count fresh input samples pushed in since the last reset
  always_comb begin
    fill_nxt = fill_r;
    valid_nxt = valid_r;
    if (dp_reset_in) begin
      fill_nxt = 8'h00;
      valid_nxt = 1'b0;
    end else begin
      if (sample_in_valid_in && (fill_r != WLBS_PIPE_DEPTH)) begin
        fill_nxt = fill_r + 8'h01;
      end
      valid_nxt = raw_valid_in && (fill_r == WLBS_PIPE_DEPTH);
    end
  end

  // register state
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      fill_r <= 8'h00;
      valid_r <= 1'b0;
    end else begin
      fill_r <= fill_nxt;
      valid_r <= valid_nxt;
    end
  end

  assign output_sample_valid_out = valid_r;

endmodule

/* wlbs_regs.sv */
// Functional notes
// - lock register at 0x000; key field bits 31:16 write-only, reads zero
// - key 0xC705 sets lock, key 0x5E5A clears it
// - lock flag is bit 0, read-only, written data there ignored
// - while locked, writes to other registers fail with slave error
// - writes to the lock register are always accepted
// - unknown key leaves lock unchanged and gives no error
// - lock resets to zero; bits 15:1 read zero
// - bank select bit 0 at 0x004: 0 bank A active, 1 bank B
// - writes into the active bank get slave error
// - shadow bank is writable and does not feed the datapath
// - bank select starts zero, untouched by register reset
// - every bank select write made while unlocked triggers a datapath reset
// - output valid low after that reset until pipeline refills
// - bank switch reset leaves filter history intact
// - config register at 0x080 is read-only and constant
// - config fields: IF 27:26, width 25:20, standard 19:16, type bit 15
// - IF code 00 zero-hertz, 01 quarter-rate; standard 0000 LTE, 0001 TD
// - width codes per LTE and TD-SCDMA bandwidths, others reserved
// - bit 14 reads gain control presence
// - bit 12 programmable frequency; bit 13 always zero
// - bits 11:6 give antenna count 1 to 8
// - bits 5:0 give carrier count 1 to 18, mask 0x3F
// - every apb transfer gets at least three wait states
// - register reset is synchronous active low, registered one cycle
`timescale 1ns/1ps
module wlbs_regs
  import wlbs_pkg::*;
#(
  parameter logic [1:0] IF_CODE = WLBS_IF_ZERO,
  parameter logic [3:0] STD_CODE = WLBS_STD_LTE,
  parameter logic [5:0] WIDTH_CODE = WLBS_BW_LTE_20M,
  parameter logic CORE_DDC = 1'b0,
  parameter logic GAIN_PROG = 1'b1,
  parameter logic FREQ_PROG = 1'b1,
  parameter logic [5:0] ANTENNAS = 6'h01,
  parameter logic [5:0] CARRIERS = 6'h01
) (
  // clock and resets
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic register_port_reset_n_in,
  // apb completer
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  // bank window access toward the bank storage
  output logic bank_wr_en_out,
  output logic [11:0] bank_wr_addr_out,
  output logic [31:0] bank_wr_data_out,
  input wire logic [31:0] bank_rd_data_in,
  // datapath control
  output logic active_bank_out,
  output logic datapath_reset_req_out,
  input wire logic sample_in_valid_in,
  input wire logic raw_valid_in,
  output logic output_sample_valid_out
);

  // build parameters are constants
  localparam wlbs_cfg_t CFG_VAL = '{
    sbz: 4'h0,
    if_code: IF_CODE,
    channel_width_code: WIDTH_CODE,
    std_code: STD_CODE,
    core_ddc: CORE_DDC,
    gain_prog: GAIN_PROG,
    phase_prog: 1'b0,
    freq_prog: FREQ_PROG,
    antennas: ANTENNAS,
    carriers: CARRIERS
  };

  typedef enum {WLBS_IDLE, WLBS_WAIT, WLBS_DONE} wlbs_state_t;

  // port reset stage
  logic preg_rst_n_r;

  // lock and bank selection
  logic lock_r;
  logic lock_nxt;
  logic bank_r;
  logic bank_nxt;

  // apb transfer sequencing and answer
  wlbs_state_t state_r;
  wlbs_state_t state_nxt;
  logic [2:0] wait_r;
  logic [2:0] wait_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic ready_r;
  logic ready_nxt;
  logic err_r;
  logic err_nxt;

  // shadow bank write port
  logic bwr_r;
  logic bwr_nxt;
  logic [11:0] bwa_r;
  logic [11:0] bwa_nxt;
  logic [31:0] bwd_r;
  logic [31:0] bwd_nxt;

  // datapath reset request
  logic dprst_r;
  logic dprst_nxt;

  // decoded request
  wlbs_req_t req;
  wlbs_dec_t dec;
  logic [15:0] key;
  logic hit_shadow;

  // register the port reset, so it acts one cycle late
  // registered reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      preg_rst_n_r <= 1'b1;
    end else begin
      preg_rst_n_r <= register_port_reset_n_in;
    end
  end

  // request and address decode
  always_comb begin
    req = '{write: pwrite_in, addr: paddr_in, wdata: pwdata_in};
    // key field of a lock write
    key = req.wdata[WLBS_KEY_MSB:WLBS_KEY_LSB];
    dec.hit_lock = (req.addr == WLBS_OFS_LOCK);
    dec.hit_bank = (req.addr == WLBS_OFS_BANK);
    dec.hit_cfg = (req.addr == WLBS_OFS_CFG);
    dec.hit_active = bank_r ? wlbs_in_range(req.addr, WLBS_BANK_B_LO, WLBS_BANK_B_HI)
                            : wlbs_in_range(req.addr, WLBS_BANK_A_LO, WLBS_BANK_A_HI);
    // shadow bank window, the one not in use
    hit_shadow = bank_r ? wlbs_in_range(req.addr, WLBS_BANK_A_LO, WLBS_BANK_A_HI)
                        : wlbs_in_range(req.addr, WLBS_BANK_B_LO, WLBS_BANK_B_HI);
  end

  // transfer sequencing, register updates and read data
  always_comb begin
    state_nxt = state_r;
    wait_nxt = wait_r;
    lock_nxt = lock_r;
    bank_nxt = bank_r;
    rdata_nxt = rdata_r;
    ready_nxt = 1'b0;
    err_nxt = 1'b0;
    bwr_nxt = 1'b0;
    bwa_nxt = bwa_r;
    bwd_nxt = bwd_r;
    dprst_nxt = 1'b0;
    case (state_r)
      WLBS_IDLE: begin
        // transfer taken on select
        rdata_nxt = 32'h0000_0000;
        if (psel_in) begin
          wait_nxt = 3'h0;
          state_nxt = WLBS_WAIT;
        end
      end
      WLBS_WAIT: begin
        if (wait_r != WLBS_WAIT_STATES) begin
          wait_nxt = wait_r + 3'h1;
        end else if (penable_in) begin
          // completes only once the access phase is open
          state_nxt = WLBS_DONE;
          ready_nxt = 1'b1;
          // read data select, then write handling
          if (!req.write) begin
            if (dec.hit_lock) begin
              rdata_nxt = {31'h0000_0000, lock_r};
            end else if (dec.hit_bank) begin
              rdata_nxt = {31'h0000_0000, bank_r};
            end else if (dec.hit_cfg) begin
              rdata_nxt = CFG_VAL;
            end else begin
              rdata_nxt = bank_rd_data_in;
            end
          end else if (dec.hit_lock) begin
            if (key == WLBS_KEY_LOCK) begin
              lock_nxt = 1'b1;
            end else if (key == WLBS_KEY_UNLOCK) begin
              lock_nxt = 1'b0;
            end
          end else if (lock_r) begin
            err_nxt = 1'b1;
          end else if (dec.hit_bank) begin
            bank_nxt = req.wdata[WLBS_BANK_BIT];
            dprst_nxt = 1'b1;
          end else if (dec.hit_active || dec.hit_cfg) begin
            err_nxt = 1'b1;
          end else if (hit_shadow) begin
            bwr_nxt = 1'b1;
            bwa_nxt = req.addr;
            bwd_nxt = req.wdata;
          end
        end
      end
      WLBS_DONE: begin
        // one idle cycle after the answer
        state_nxt = WLBS_IDLE;
        rdata_nxt = 32'h0000_0000;
      end
      default: begin
        state_nxt = WLBS_IDLE;
      end
    endcase
  end

  // register state; lock reset by port reset, bank only by power-on reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || !preg_rst_n_r) begin
      lock_r <= WLBS_LOCK_RST;
      state_r <= WLBS_IDLE;
      wait_r <= 3'h0;
      rdata_r <= 32'h0000_0000;
      ready_r <= 1'b0;
      err_r <= 1'b0;
      bwr_r <= 1'b0;
      bwa_r <= 12'h000;
      bwd_r <= 32'h0000_0000;
      dprst_r <= 1'b0;
    end else begin
      lock_r <= lock_nxt;
      state_r <= state_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
      ready_r <= ready_nxt;
      err_r <= err_nxt;
      bwr_r <= bwr_nxt;
      bwa_r <= bwa_nxt;
      bwd_r <= bwd_nxt;
      dprst_r <= dprst_nxt;
    end
  end

  // selection register, cleared only at power-on reset
  // bank kept across port reset
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      bank_r <= WLBS_BANK_INIT;
    end else if (preg_rst_n_r) begin
      bank_r <= bank_nxt;
    end
  end

  // only valid gating cleared, history untouched
  wlbs_valid_gate u_valid_gate (
    .sys_clk_in(sys_clk_in),
    .srst_in(srst_in),
    .dp_reset_in(dprst_r),
    .sample_in_valid_in(sample_in_valid_in),
    .raw_valid_in(raw_valid_in),
    .output_sample_valid_out(output_sample_valid_out)
  );

  // outputs straight from flops: apb answer
  assign prdata_out = rdata_r;
  assign pready_out = ready_r;
  assign pslverr_out = err_r;

  // shadow bank write port
  assign bank_wr_en_out = bwr_r;
  assign bank_wr_addr_out = bwa_r;
  assign bank_wr_data_out = bwd_r;

  // datapath control
  assign active_bank_out = bank_r;
  assign datapath_reset_req_out = dprst_r;

endmodule

/* wlbs_checker.sv */
`timescale 1ns/1ps
module wlbs_checker
  import wlbs_pkg::*;
(
  // clock and resets
  input wire logic sys_clk_in,
  input wire logic srst_in,
  input wire logic register_port_reset_n_in,
  // apb side
  input wire logic psel_in,
  input wire logic pwrite_in,
  input wire logic [11:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  input wire logic [31:0] prdata_out,
  input wire logic pready_out,
  input wire logic pslverr_out,
  // bank and datapath side
  input wire logic bank_wr_en_out,
  input wire logic [11:0] bank_wr_addr_out,
  input wire logic active_bank_out,
  input wire logic datapath_reset_req_out,
  input wire logic output_sample_valid_out
);
  default clocking @(posedge sys_clk_in); endclocking
  default disable iff (srst_in || !register_port_reset_n_in);
  // completed bank select write
  logic bank_wr;
  assign bank_wr = pready_out && pwrite_in && psel_in && (paddr_in == WLBS_OFS_BANK);
  // transfer phases
  sequence s_wait; !pready_out [*4]; endsequence
  sequence s_done; ##[0:7] pready_out; endsequence
  property p_wait; $rose(psel_in) |-> s_wait ##1 s_done; endproperty
  property p_pulse; pready_out |=> !pready_out; endproperty
  property p_err; pslverr_out |-> pready_out && pwrite_in; endproperty
  property p_lock_rd; pready_out && !pwrite_in && paddr_in == WLBS_OFS_LOCK |-> prdata_out[31:1] == 31'h0; endproperty
  property p_bank; bank_wr && !pslverr_out |-> datapath_reset_req_out && active_bank_out == pwdata_in[0]; endproperty
  property p_bank_cause; $changed(active_bank_out) |-> bank_wr; endproperty
  property p_valid; datapath_reset_req_out |=> !output_sample_valid_out; endproperty
  property p_shadow;
    bank_wr_en_out |-> (active_bank_out ? (bank_wr_addr_out >= WLBS_BANK_A_LO && bank_wr_addr_out <= WLBS_BANK_A_HI)
      : (bank_wr_addr_out >= WLBS_BANK_B_LO && bank_wr_addr_out <= WLBS_BANK_B_HI));
  endproperty
  a_wait: assert property (p_wait) else $error("ready too early or late");
  a_pulse: assert property (p_pulse) else $error("ready longer than one cycle");
  a_err: assert property (p_err) else $error("error outside write answer");
  a_lock_rd: assert property (p_lock_rd) else $error("lock key or reserved bits read nonzero");
  a_bank: assert property (p_bank) else $error("bank write without reset or select");
  a_bank_cause: assert property (p_bank_cause) else $error("bank changed without write");
  a_valid: assert property (p_valid) else $error("valid high after datapath reset");
  a_shadow: assert property (p_shadow) else $error("write reached active bank");
endmodule

/* wlbs_apb_req.sv */
`timescale 1ns/1ps
module wlbs_apb_req (
  // clock
  input wire logic sys_clk_in,
  // answer
  input wire logic pready_in,
  input wire logic pslverr_in,
  input wire logic [31:0] prdata_in,
  // request
  output logic psel_out,
  output logic penable_out,
  output logic pwrite_out,
  output logic [11:0] paddr_out,
  output logic [31:0] pwdata_out
);
  // idle bus at time zero
  initial begin
    psel_out = 1'b0;
    penable_out = 1'b0;
    pwrite_out = 1'b0;
    paddr_out = 12'hFFF;
    pwdata_out = 32'hFFFF_FFFF;
  end
  // one transfer, gap idle cycles first
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input int gap,
      output logic [31:0] rd, output logic err, output int ws);
    repeat (gap) @(posedge sys_clk_in);
    psel_out <= 1'b1;
    pwrite_out <= w;
    paddr_out <= a;
    pwdata_out <= d;
    @(posedge sys_clk_in);
    penable_out <= 1'b1;
    ws = 0;
    @(posedge sys_clk_in);
    while (pready_in !== 1'b1 && ws < 20) begin
      ws++;
      @(posedge sys_clk_in);
    end
    rd = prdata_in;
    err = pslverr_in;
    // released bus shows inverse values
    psel_out <= 1'b0;
    penable_out <= 1'b0;
    paddr_out <= ~a;
    pwdata_out <= ~d;
    @(posedge sys_clk_in);
  endtask
endmodule

/* testbench.sv */
`timescale 1ns/1ps
module testbench
  import wlbs_pkg::*;
;
  localparam logic [31:0] zero = 32'h0000_0000;
  localparam logic [31:0] one = 32'h0000_0001;
  localparam logic [31:0] cfg = 32'h0540_9212;
  logic sys_clk_in = 1'b0;
  logic srst_in = 1'b1;
  logic register_port_reset_n_in = 1'b1;
  logic psel_in, penable_in, pwrite_in;
  logic [11:0] paddr_in;
  logic [31:0] pwdata_in, prdata_out;
  logic pready_out, pslverr_out, bank_wr_en_out, active_bank_out, datapath_reset_req_out;
  logic [11:0] bank_wr_addr_out, bw_addr;
  logic [31:0] bank_wr_data_out, bw_data;
  logic [31:0] bank_rd_data_in;
  // bank storage model: read data follows the address
  assign bank_rd_data_in = {20'hA_5A50, paddr_in};
  logic sample_in_valid_in = 1'b0;
  logic raw_valid_in = 1'b0;
  logic output_sample_valid_out;
  logic [31:0] rd;
  logic err;
  int ws;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int n_dpr = 0;
  // clock
  always #10 sys_clk_in = ~sys_clk_in;
  wlbs_regs #(.IF_CODE(2'h1), .CORE_DDC(1'b1), .GAIN_PROG(1'b0), .ANTENNAS(6'h08),
      .CARRIERS(6'h12)) i_wlbs_regs (.sys_clk_in, .srst_in,
      .register_port_reset_n_in, .psel_in, .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
      .pready_out, .pslverr_out, .bank_wr_en_out, .bank_wr_addr_out, .bank_wr_data_out, .bank_rd_data_in,
      .active_bank_out, .datapath_reset_req_out, .sample_in_valid_in, .raw_valid_in, .output_sample_valid_out);
  wlbs_apb_req i_wlbs_apb_req (.sys_clk_in(sys_clk_in), .pready_in(pready_out), .pslverr_in(pslverr_out),
      .prdata_in(prdata_out), .psel_out(psel_in), .penable_out(penable_in), .pwrite_out(pwrite_in),
      .paddr_out(paddr_in), .pwdata_out(pwdata_in));
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      errors++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d, input int gap);
    i_wlbs_apb_req.xfer(w, a, d, gap, rd, err, ws);
    chk("wait_states", 32'h0000_0004, 32'(ws));
  endtask
  task automatic print_verdict;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic s_reset_vals;
    bus(1'b0, WLBS_OFS_LOCK, zero, 0);
    chk("lock_rst", zero, rd);
    bus(1'b0, WLBS_OFS_BANK, zero, 3);
    chk("bank_rst", zero, rd);
    bus(1'b0, WLBS_OFS_CFG, zero, 0);
    chk("cfg", cfg, rd);
    chk("carriers", 32'h0000_0012, rd & 32'h0000_003F);
  endtask
  task automatic s_cfg_ro;
    bus(1'b1, WLBS_OFS_CFG, 32'hFFFF_FFFF, 0);
    chk("cfg_wr_err", one, 32'(err));
    bus(1'b0, WLBS_OFS_CFG, zero, 0);
    chk("cfg_const", cfg, rd);
  endtask
  task automatic s_lock;
    bus(1'b1, WLBS_OFS_LOCK, {16'hC705, 16'hFFFE}, 0);
    chk("lock_err", zero, 32'(err));
    bus(1'b0, WLBS_OFS_LOCK, zero, 0);
    chk("locked", one, rd);
    bus(1'b1, WLBS_OFS_BANK, one, 0);
    chk("locked_err", one, 32'(err));
    bus(1'b0, WLBS_OFS_BANK, zero, 0);
    chk("bank_kept", zero, rd);
    bus(1'b1, WLBS_OFS_LOCK, {16'h1234, 16'h0000}, 0);
    chk("badkey_err", zero, 32'(err));
    bus(1'b0, WLBS_OFS_LOCK, zero, 0);
    chk("badkey_lock", one, rd);
    bus(1'b1, WLBS_OFS_LOCK, {16'h5E5A, 16'h0001}, 0);
    chk("unlock_err", zero, 32'(err));
    bus(1'b0, WLBS_OFS_LOCK, zero, 0);
    chk("unlocked", zero, rd);
  endtask
  task automatic s_bank;
    n_dpr = 0;
    bus(1'b1, WLBS_OFS_BANK, 32'hFFFF_FFFF, 0);
    chk("active_b", one, 32'(active_bank_out));
    bus(1'b0, WLBS_OFS_BANK, zero, 0);
    chk("bank_rd", one, rd);
    bus(1'b1, 12'h500, 32'h1111_2222, 0);
    chk("active_err", one, 32'(err));
    bus(1'b1, 12'h344, 32'h3333_4444, 0);
    chk("shadow_err", zero, 32'(err));
    chk("shadow_addr", 32'h0000_0344, 32'(bw_addr));
    chk("shadow_data", 32'h3333_4444, bw_data);
    bus(1'b0, 12'h344, zero, 0);
    chk("shadow_rd", 32'hA5A5_0344, rd);
    bus(1'b1, WLBS_OFS_BANK, one, 0);
    chk("dp_resets", 32'h0000_0002, 32'(n_dpr));
    bus(1'b1, WLBS_OFS_BANK, zero, 0);
    chk("active_a", zero, 32'(active_bank_out));
    bus(1'b1, 12'h100, 32'h5555_6666, 0);
    chk("active_a_err", one, 32'(err));
  endtask
  task automatic s_valid;
    raw_valid_in <= 1'b1;
    sample_in_valid_in <= 1'b1;
    repeat (40) @(posedge sys_clk_in);
    sample_in_valid_in <= 1'b0;
    bus(1'b1, WLBS_OFS_BANK, zero, 0);
    repeat (40) @(posedge sys_clk_in);
    chk("valid_hold", zero, 32'(output_sample_valid_out));
    sample_in_valid_in <= 1'b1;
    repeat (40) @(posedge sys_clk_in);
    chk("valid_back", one, 32'(output_sample_valid_out));
  endtask
  task automatic s_port_reset;
    bus(1'b1, WLBS_OFS_BANK, one, 0);
    bus(1'b1, WLBS_OFS_LOCK, {16'hC705, 16'h0000}, 0);
    register_port_reset_n_in <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    register_port_reset_n_in <= 1'b1;
    repeat (3) @(posedge sys_clk_in);
    bus(1'b0, WLBS_OFS_LOCK, zero, 0);
    chk("lock_prst", zero, rd);
    bus(1'b0, WLBS_OFS_BANK, zero, 0);
    chk("bank_prst", one, rd);
  endtask
  // cycle count, monitors and hang limit
  always @(posedge sys_clk_in) begin
    cyc++;
    if (datapath_reset_req_out === 1'b1) n_dpr++;
    if (bank_wr_en_out === 1'b1) begin
      bw_addr = bank_wr_addr_out;
      bw_data = bank_wr_data_out;
    end
    if (cyc == 5000) begin
      errors++;
      print_verdict;
    end
  end
  // main sequence
  initial begin
    repeat (4) @(posedge sys_clk_in);
    srst_in <= 1'b0;
    @(posedge sys_clk_in);
    s_reset_vals;
    s_cfg_ro;
    s_lock;
    s_bank;
    s_valid;
    s_port_reset;
    print_verdict;
  end
endmodule
bind wlbs_regs wlbs_checker i_wlbs_checker (.sys_clk_in, .srst_in, .register_port_reset_n_in, .psel_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out, .pslverr_out, .bank_wr_en_out,
    .bank_wr_addr_out, .active_bank_out, .datapath_reset_req_out, .output_sample_valid_out);
